// ==== adcs_regs.svh ====
`ifndef ADCS_REGS_SVH
`define ADCS_REGS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ADCS_CTL_A_OFS 8'h00
`define ADCS_CTL_B_OFS 8'h04
`define ADCS_RES_A_OFS 8'h10
`define ADCS_RES_B_OFS 8'h14
`define ADCS_CFG_OFS 8'h20
// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define ADCS_DONE_BIT 7
`define ADCS_IE_BIT 6
`define ADCS_DIFFERENTIAL_SELECT_BIT 5
`define ADCS_CH_MSB 4
`define ADCS_CH_DIS 5'h1F
`define ADCS_CTL_RST 7'h1F
`define ADCS_SEL_RST 7'h1F
`define ADCS_CFG_RST 6'h00
`define ADCS_AVG_BASE 7'h04
`endif

// ==== adcs_pkg.sv ====
package adcs_pkg;
  typedef struct packed {
    logic       ie;
    logic       differential_select;
    logic [4:0] ch;
  } adcs_ctl_type;

  typedef struct packed {
    logic       trig;
    logic       cont;
    logic [1:0] average_count_select;
    logic       avg_en;
    logic       cmp_en;
  } adcs_cfg_type;

  typedef struct packed {
    logic       valid;
    logic       differential_select;
    logic [4:0] ch;
  } adcs_sel_type;

  typedef enum logic [0:0] {
    ADCS_IDLE = 1'b0,
    ADCS_CONV = 1'b1
  } adcs_state_type;
endpackage : adcs_pkg

// ==== adcs_ctrl.sv ====
// Added by the designer: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`include "adcs_regs.svh"
module adcs_ctrl
  import adcs_pkg::*;
#(
  parameter int RES_W = 16
)
(
  input  wire logic             clock_i,
  input  wire logic             sys_rst_i,
  input  wire logic [7:0]       avs_address_i,
  input  wire logic             avs_read_i,
  input  wire logic             avs_write_i,
  input  wire logic [31:0]      avs_writedata_i,
  input  wire logic [3:0]       avs_byteenable_i,
  output logic      [31:0]      avs_readdata_o,
  output logic                  avs_waitrequest_o,
  input  wire logic             conv_done_i,
  input  wire logic             compare_true_i,
  input  wire logic [RES_W-1:0] result_i,
  input  wire logic             cal_done_i,
  input  wire logic             hw_trig_i,
  input  wire logic             hw_trig_sel_i,
  output logic                  conv_start_o,
  output logic                  conv_abort_o,
  output logic                  converter_on_o,
  output logic                  low_power_o,
  output adcs_sel_type          input_sel_o,
  output logic                  irq_o
);

  // ----------------------------------------
  // channel decode
  // ----------------------------------------
  function automatic adcs_sel_type chan_decode(input logic [4:0] ch, input logic differential_select);
    adcs_sel_type s;
    s.ch   = ch;
    s.differential_select = differential_select;
    if (differential_select)
    begin
      s.valid = (ch < 5'h04) || (ch == 5'h1A) || (ch == 5'h1B) || (ch == 5'h1D);
    end
    else
    begin
      s.valid = !((ch == 5'h18) || (ch == 5'h19) || (ch == 5'h1C) || (ch == `ADCS_CH_DIS));
    end
    return s;
  endfunction : chan_decode

  // ----------------------------------------
  // state
  // ----------------------------------------
  adcs_ctl_type     ctl_r [2];
  adcs_ctl_type     ctl_nxt [2];
  logic [1:0]       flag_r;
  logic [1:0]       flag_nxt;
  adcs_cfg_type     cfg_r;
  adcs_cfg_type     cfg_nxt;
  adcs_state_type   state_r;
  adcs_state_type   state_nxt;
  logic             act_r;
  logic             act_nxt;
  logic [6:0]       avg_cnt_r;
  logic [6:0]       avg_cnt_nxt;
  logic [RES_W-1:0] res_r [2];
  logic [RES_W-1:0] res_nxt [2];
  logic             wait_r;
  logic             wait_nxt;
  logic [31:0]      rdata_r;
  logic [31:0]      rdata_nxt;
  logic             start_r;
  logic             start_nxt;
  logic             abort_r;
  logic             abort_nxt;
  logic             on_r;
  logic             on_nxt;
  logic             lowpwr_r;
  logic             lowpwr_nxt;
  adcs_sel_type     sel_r;
  adcs_sel_type     sel_nxt;
  logic             irq_r;
  logic             irq_nxt;

  logic             wr_acc;
  logic             rd_acc;
  logic [1:0]       wr_ctl;
  logic [1:0]       rd_res;
  logic [1:0]       set_vec;
  logic             done_ev;
  logic             fin_ev;
  logic [4:0]       wd_ch;
  logic [6:0]       avg_need;

  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign conv_start_o      = start_r;
  assign conv_abort_o      = abort_r;
  assign converter_on_o    = on_r;
  assign low_power_o       = lowpwr_r;
  assign input_sel_o       = sel_r;
  assign irq_o             = irq_r;

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------
  always_comb
  begin
    wr_acc    = avs_write_i && !wait_r;
    rd_acc    = avs_read_i && !wait_r;
    wd_ch     = avs_writedata_i[`ADCS_CH_MSB:0];
    wr_ctl[0] = wr_acc && avs_byteenable_i[0] && (avs_address_i == `ADCS_CTL_A_OFS);
    wr_ctl[1] = wr_acc && avs_byteenable_i[0] && (avs_address_i == `ADCS_CTL_B_OFS);
    rd_res[0] = rd_acc && (avs_address_i == `ADCS_RES_A_OFS);
    rd_res[1] = rd_acc && (avs_address_i == `ADCS_RES_B_OFS);
    avg_need  = `ADCS_AVG_BASE << cfg_r.average_count_select;
    ctl_nxt   = ctl_r;
    cfg_nxt   = cfg_r;
    res_nxt   = res_r;
    state_nxt = state_r;
    act_nxt   = act_r;
    avg_cnt_nxt = avg_cnt_r;
    start_nxt = 1'b0;
    abort_nxt = 1'b0;
    done_ev   = 1'b0;
    fin_ev    = 1'b0;
    set_vec   = 2'b00;
    // bus handshake: one wait cycle, then accept
    wait_nxt  = !((avs_read_i || avs_write_i) && wait_r);
    rdata_nxt = rdata_r;
    if ((avs_read_i || avs_write_i) && wait_r)
    begin
      unique case (avs_address_i)
        `ADCS_CTL_A_OFS: rdata_nxt = {24'h000000, flag_r[0], ctl_r[0]};
        `ADCS_CTL_B_OFS: rdata_nxt = {24'h000000, flag_r[1], ctl_r[1]};
        `ADCS_RES_A_OFS: rdata_nxt = {{(32-RES_W){1'b0}}, res_r[0]};
        `ADCS_RES_B_OFS: rdata_nxt = {{(32-RES_W){1'b0}}, res_r[1]};
        `ADCS_CFG_OFS:   rdata_nxt = {26'h0, cfg_r};
        default:         rdata_nxt = 32'h00000000;
      endcase
    end
    for (int i = 0; i < 2; i++)
    begin
      if (wr_ctl[i])
      begin
        ctl_nxt[i] = avs_writedata_i[`ADCS_IE_BIT:0];
      end
    end
    if (wr_acc && avs_byteenable_i[0] && (avs_address_i == `ADCS_CFG_OFS))
    begin
      cfg_nxt = avs_writedata_i[5:0];
    end
    unique case (state_r)
      ADCS_IDLE:
      begin
        if (wr_ctl[0] && !cfg_r.trig && (wd_ch != `ADCS_CH_DIS))
        begin
          state_nxt   = ADCS_CONV;
          act_nxt     = 1'b0;
          start_nxt   = 1'b1;
          avg_cnt_nxt = 7'h00;
        end
        else if (hw_trig_i && cfg_r.trig && (ctl_r[hw_trig_sel_i].ch != `ADCS_CH_DIS))
        begin
          state_nxt   = ADCS_CONV;
          act_nxt     = hw_trig_sel_i;
          start_nxt   = 1'b1;
          avg_cnt_nxt = 7'h00;
        end
      end
      ADCS_CONV:
      begin
        if (wr_ctl[act_r])
        begin
          abort_nxt   = 1'b1;
          avg_cnt_nxt = 7'h00;
          if (!act_r && !cfg_r.trig && (wd_ch != `ADCS_CH_DIS))
          begin
            start_nxt = 1'b1;
          end
          else
          begin
            state_nxt = ADCS_IDLE;
          end
        end
        else if (conv_done_i)
        begin
          done_ev      = 1'b1;
          res_nxt[act_r] = result_i;
          if (cfg_r.avg_en && (avg_cnt_r + 7'h01 != avg_need))
          begin
            avg_cnt_nxt = avg_cnt_r + 7'h01;
          end
          else
          begin
            fin_ev      = 1'b1;
            avg_cnt_nxt = 7'h00;
          end
          if (cfg_r.cont && (ctl_r[act_r].ch != `ADCS_CH_DIS))
          begin
            start_nxt = 1'b1;
          end
          else
          begin
            state_nxt = ADCS_IDLE;
          end
        end
      end
    endcase
    // flag set wins over clear
    set_vec[act_r] = fin_ev && (!cfg_r.cmp_en || compare_true_i);
    set_vec[0]     = set_vec[0] || cal_done_i;
    for (int i = 0; i < 2; i++)
    begin
      flag_nxt[i] = set_vec[i] || (flag_r[i] && !(wr_ctl[i] || rd_res[i]));
    end
    irq_nxt    = (flag_nxt[0] && ctl_nxt[0].ie) || (flag_nxt[1] && ctl_nxt[1].ie);
    on_nxt     = ctl_nxt[act_nxt].ch != `ADCS_CH_DIS;
    lowpwr_nxt = !on_nxt || ((state_nxt == ADCS_IDLE) && !cfg_nxt.cont);
    sel_nxt    = chan_decode(ctl_nxt[act_nxt].ch, ctl_nxt[act_nxt].differential_select);
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  always_ff @(posedge clock_i)
  begin
    if (sys_rst_i)
    begin
      ctl_r[0]  <= `ADCS_CTL_RST;
      ctl_r[1]  <= `ADCS_CTL_RST;
      flag_r    <= 2'b00;
      cfg_r     <= `ADCS_CFG_RST;
      state_r   <= ADCS_IDLE;
      act_r     <= 1'b0;
      avg_cnt_r <= 7'h00;
      res_r[0]  <= '0;
      res_r[1]  <= '0;
      wait_r    <= 1'b1;
      rdata_r   <= 32'h00000000;
      start_r   <= 1'b0;
      abort_r   <= 1'b0;
      on_r      <= 1'b0;
      lowpwr_r  <= 1'b1;
      sel_r     <= `ADCS_SEL_RST;
      irq_r     <= 1'b0;
    end
    else
    begin
      ctl_r     <= ctl_nxt;
      flag_r    <= flag_nxt;
      cfg_r     <= cfg_nxt;
      state_r   <= state_nxt;
      act_r     <= act_nxt;
      avg_cnt_r <= avg_cnt_nxt;
      res_r     <= res_nxt;
      wait_r    <= wait_nxt;
      rdata_r   <= rdata_nxt;
      start_r   <= start_nxt;
      abort_r   <= abort_nxt;
      on_r      <= on_nxt;
      lowpwr_r  <= lowpwr_nxt;
      sel_r     <= sel_nxt;
      irq_r     <= irq_nxt;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  cal_flag_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    cal_done_i |=> flag_r[0])
    else $error("calibration end did not set flag");
  clear_flag_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (wr_ctl[1] || rd_res[1]) && !(act_r && conv_done_i) |=> !flag_r[1])
    else $error("flag not cleared");
  single_done_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    done_ev && !cfg_r.cmp_en && !cfg_r.avg_en |=> flag_r[$past(act_r)])
    else $error("conversion end did not set flag");
  compare_gate_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !flag_r[0] && cfg_r.cmp_en && !compare_true_i && !cal_done_i |=> !flag_r[0])
    else $error("flag set with false compare");
  avg_hold_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !flag_r[0] && cfg_r.avg_en && avg_cnt_r == 7'h00 && !cal_done_i |=> !flag_r[0])
    else $error("flag set before averaging done");
  irq_level_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    (flag_r[0] && ctl_r[0].ie) || (flag_r[1] && ctl_r[1].ie) |-> irq_r)
    else $error("interrupt not held");
  irq_off_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    irq_r |-> (flag_r[0] && ctl_r[0].ie) || (flag_r[1] && ctl_r[1].ie))
    else $error("interrupt without enabled flag");
  sw_start_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    wr_ctl[0] && !cfg_r.trig && wd_ch != `ADCS_CH_DIS |=> start_r && state_r == ADCS_CONV && !act_r)
    else $error("primary write did not start");
  no_start_b_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_r == ADCS_IDLE && !cfg_r.trig && !wr_ctl[0] |=> !start_r)
    else $error("start without primary write");
  abort_run_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_r == ADCS_CONV && wr_ctl[act_r] |=> abort_r)
    else $error("active write did not abort");
  stop_dis_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_r == ADCS_CONV && wr_ctl[act_r] && wd_ch == `ADCS_CH_DIS |=> !start_r && !on_r ##1 !start_r)
    else $error("conversion after disable code");
  low_power_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state_r == ADCS_CONV && conv_done_i && !cfg_r.cont && !wr_ctl[act_r] && !cfg_nxt.cont |=> lowpwr_r)
    else $error("no low power after conversion");
  off_iso_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !on_r |-> lowpwr_r && !sel_r.valid)
    else $error("disabled converter not isolated");
  differential_select_decode_a: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    sel_r.valid && sel_r.differential_select |-> sel_r.ch < 5'h04 || sel_r.ch > 5'h19)
    else $error("reserved differential code accepted");

endmodule : adcs_ctrl

// ==== test_adcs_ctrl.sv ====
`timescale 1ns/100ps
module test_adcs_ctrl;
  import adcs_pkg::*;
  logic         clock_i = 0, sys_rst_i = 1, rd = 0, wr = 0, cd = 0, ct = 0, cal = 0, trg = 0, tsel = 0;
  logic [7:0]   adr = 0;
  logic [31:0]  wd = 0, rdat, rdo;
  logic [15:0]  res = 0;
  logic         wt, st, ab, on, lp, irq;
  adcs_sel_type sel;
  logic [5:0]   v;
  logic [4:0]   prev;
  logic [1:0]   a;
  int           bad_count = 0, checked = 0, cyc = 0, n;

  adcs_ctrl adcs_ctrl_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .avs_address_i(adr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wt), .conv_done_i(cd), .compare_true_i(ct), .result_i(res), .cal_done_i(cal),
    .hw_trig_i(trg), .hw_trig_sel_i(tsel), .conv_start_o(st), .conv_abort_o(ab), .converter_on_o(on),
    .low_power_o(lp), .input_sel_o(sel), .irq_o(irq));

  initial
  begin
    forever #2.5 clock_i = ~clock_i;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic close_out;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  // one access; returns just after the accept edge
  task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge clock_i);
    adr <= ad;
    wd  <= d;
    wr  <= w;
    rd  <= !w;
    do
    begin
      @(posedge clock_i);
    end while (wt !== 1'b0);
    rdat = rdo;
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
  endtask : bus

  // one finished conversion; returns when a raised flag has reached irq
  task automatic conv_pulse(input logic cmp);
    @(posedge clock_i);
    cd  <= 1'b1;
    ct  <= cmp;
    res <= 16'($urandom);
    @(posedge clock_i);
    cd <= 1'b0;
    @(posedge clock_i);
    #1;
  endtask : conv_pulse

  function automatic logic [6:0] dec(input logic df, input logic [4:0] c);
    logic [31:0] differential_select_ok;
    logic [31:0] se_bad;
    differential_select_ok = 32'h2C00000F;
    se_bad  = 32'h93000000;
    return {df ? differential_select_ok[c] : !se_bad[c], df, c};
  endfunction : dec

  always @(posedge clock_i)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      close_out();
    end
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial
  begin
    void'($urandom(86359));
    repeat (8) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    #1;
    chk("low_power", lp, 1);
    chk("input_sel", sel, 7'h1F);
    chk("waitrequest", wt, 1);
    bus(0, 8'h00, 0);
    chk("ctl_a", rdat, 32'h1F);
    bus(0, 8'h04, 0);
    chk("ctl_b", rdat, 32'h1F);
    bus(0, 8'h30, 0);
    chk("unmapped", rdat, 0);
    prev = 5'h1F;
    for (int i = 0; i < 80; i++)
    begin
      v = (i < 64) ? 6'(i) : 6'($urandom);
      bus(1, 8'h00, {26'h0, v});
      chk("start", st, v[4:0] != 5'h1F);
      chk("abort", ab, prev != 5'h1F);
      chk("input_sel", sel, dec(v[5], v[4:0]));
      chk("conv_on", on, v[4:0] != 5'h1F);
      prev = v[4:0];
    end
    bus(1, 8'h04, 32'h03);
    chk("start_b", st, 0);
    chk("abort_b", ab, 0);
    bus(1, 8'h00, 32'h43);
    conv_pulse(0);
    chk("irq_set", irq, 1);
    chk("low_power", lp, 1);
    bus(0, 8'h00, 0);
    chk("flag_set", rdat, 32'hC3);
    chk("irq_hold", irq, 1);
    bus(0, 8'h10, 0);
    chk("result_a", rdat, {16'h0, res});
    @(posedge clock_i);
    #1;
    chk("irq_clr", irq, 0);
    bus(0, 8'h00, 0);
    chk("flag_clr", rdat, 32'h43);
    bus(1, 8'h20, 32'h01);
    bus(1, 8'h00, 32'h43);
    conv_pulse(0);
    bus(0, 8'h00, 0);
    chk("cmp_false", rdat, 32'h43);
    bus(1, 8'h00, 32'h43);
    conv_pulse(1);
    bus(0, 8'h00, 0);
    chk("cmp_true", rdat, 32'hC3);
    a = 2'($urandom_range(3));
    n = 4 << a;
    bus(1, 8'h20, {27'h0, 1'b1, a, 2'b10});
    bus(1, 8'h00, 32'h03);
    repeat (n - 1) conv_pulse(1);
    bus(0, 8'h00, 0);
    chk("avg_early", rdat, 32'h03);
    conv_pulse(1);
    bus(0, 8'h00, 0);
    chk("avg_done", rdat, 32'h83);
    bus(1, 8'h00, 32'h1F);
    chk("stop_abort", ab, 1);
    chk("stop_on", on, 0);
    repeat (4)
    begin
      chk("stop_start", st, 0);
      @(posedge clock_i);
      #1;
    end
    chk("stop_lp", lp, 1);
    @(posedge clock_i);
    cal <= 1'b1;
    @(posedge clock_i);
    cal <= 1'b0;
    bus(0, 8'h00, 0);
    chk("cal_flag", rdat, 32'h9F);
    chk("irq_mask", irq, 0);
    // hardware trigger on the secondary register
    bus(1, 8'h20, 32'h20);
    bus(1, 8'h04, 32'h45);
    chk("hw_b_write", st, 0);
    bus(1, 8'h00, 32'h03);
    chk("hw_a_write", st, 0);
    @(posedge clock_i);
    trg  <= 1'b1;
    tsel <= 1'b1;
    @(posedge clock_i);
    trg  <= 1'b0;
    tsel <= 1'b0;
    #1;
    chk("hw_start", st, 1);
    chk("hw_sel", sel, dec(0, 5'h05));
    conv_pulse(1);
    chk("irq_b", irq, 1);
    bus(0, 8'h04, 0);
    chk("flag_b", rdat, 32'hC5);
    bus(0, 8'h14, 0);
    chk("result_b", rdat, {16'h0, res});
    chk("irq_b_clr", irq, 0);
    bus(0, 8'h04, 0);
    chk("flag_b_clr", rdat, 32'h45);
    close_out();
  end
endmodule : test_adcs_ctrl
